// ---- rtl/cra_pkg.sv ----
// Shared constants and types for the coherent response and acknowledge link
package cra_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int LINE_OFS_W = 6;
   localparam logic [2:0] SIZE_BUS = 3'h2;
   localparam logic [1:0] BURST_INCR = 2'h1;
   localparam logic [3:0] CACHE_NORMAL_NC = 4'h2;
   localparam logic LOCK_NORMAL = 1'b0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_EXCL_OK = 2'h1;
   localparam int RESP_DUTY_BIT = 2;
   localparam int RESP_SHARED_BIT = 3;
   // Register offsets of the controller
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   // Control register fields
   localparam int CTRL_KIND_LSB = 0;
   localparam int CTRL_WRITE_BIT = 4;
   localparam int CTRL_BAR_BIT = 5;
   localparam int CTRL_LOCK_BIT = 6;
   localparam int CTRL_DOMAIN_LSB = 8;
   localparam int CTRL_PROT_LSB = 10;
   localparam int CTRL_LEN_LSB = 16;
   localparam int CTRL_CACHE_LSB = 24;
   localparam int CTRL_GO_BIT = 31;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Status register fields
   localparam int ST_RD_BUSY = 0;
   localparam int ST_WR_BUSY = 1;
   localparam int ST_RRESP_LSB = 2;
   localparam int ST_BRESP_LSB = 6;
   localparam int ST_DUTY = 8;
   localparam int ST_SHARED = 9;
   localparam int ST_REFUSED = 10;

   typedef enum logic [3:0] {
      K_NONCOH_READ = 4'h0,
      K_SNAPSHOT_READ = 4'h1,
      K_CLEAN_COPY_READ = 4'h2,
      K_NONSHARED_DIRTY_READ = 4'h3,
      K_SHARED_READ = 4'h4,
      K_EXCL_COPY_READ = 4'h5,
      K_CLEAN_TO_OWN = 4'h6,
      K_MAKE_OWN = 4'h7,
      K_CLEAN_KEEP = 4'h8,
      K_CLEAN_AND_DROP = 4'h9,
      K_DROP_ALL_COPIES = 4'hA,
      K_VM_MESSAGE = 4'hB
   } cra_kind_t;
   // Write kinds share the snoop field
   localparam logic [3:0] K_NONCOH_WRITE = 4'h0;

   typedef struct packed {
      logic [ADDR_W-1:0] request_address;
      logic [7:0] burst_beats;
      logic [2:0] beat_size;
      logic [1:0] burst_kind;
      logic [3:0] cache_attributes;
      logic [2:0] protection_field;
      logic lock_type;
      logic [3:0] snoop_type;
      logic barrier_flag;
      logic [1:0] domain;
   } cra_req_t;

   function automatic logic cra_single_beat(input cra_req_t r);
      cra_single_beat = r.barrier_flag ||
         (r.snoop_type inside {K_CLEAN_TO_OWN, K_MAKE_OWN, K_CLEAN_KEEP,
         K_CLEAN_AND_DROP, K_DROP_ALL_COPIES, K_VM_MESSAGE});
   endfunction
endpackage

// ---- rtl/cra_if.sv ----
// Link between the cached master and the coherent interconnect
`timescale 1ns/10ps
interface cra_if (
   input wire logic pclk,
   input wire logic presetn
);
   import cra_pkg::*;
   logic ar_valid, ar_ready, aw_valid, aw_ready;
   cra_req_t ar, aw;
   logic r_valid, r_ready, r_last;
   logic [DATA_W-1:0] r_data, w_data;
   logic [3:0] r_resp;
   logic w_valid, w_ready, w_last;
   logic b_valid, b_ready;
   logic [1:0] b_resp;
   logic read_completion_ack, write_completion_ack;

   modport master (
      output ar_valid, ar, r_ready, read_completion_ack,
      output aw_valid, aw, w_valid, w_data, w_last, b_ready,
      output write_completion_ack,
      input ar_ready, r_valid, r_data, r_resp, r_last,
      input aw_ready, w_ready, b_valid, b_resp
   );
   modport fabric (
      input ar_valid, ar, r_ready, read_completion_ack,
      input aw_valid, aw, w_valid, w_data, w_last, b_ready,
      input write_completion_ack,
      output ar_ready, r_valid, r_data, r_resp, r_last,
      output aw_ready, w_ready, b_valid, b_resp
   );
endinterface

// ---- rtl/cra_master.sv ----
// Cached master end: APB command registers, request issue, acknowledges
`timescale 1ns/10ps
// Overview of operation
// - Barrier: zero address, length, snoop; INCR, bus size
// - Barrier uses normal non-cacheable cache, normal lock
// - Writeback-duty bit makes master owe the writeback
// - Other-copy bit forces shared line state
// - Interconnect keeps coherency bits constant per burst
// - Other-copy low for copy-removing transactions
// - Writeback-duty low where dirty data cannot pass
// - Both bits low for noncoherent, barrier, message
// - Only permitted bit pairs per transaction kind
// - Dataless kinds return one last beat, data ignored
// - Read exclusive-OK only for four kinds
// - Read acknowledge one cycle, taken without backpressure
// - Read acknowledge after last beat, never postponed
// - Every read-side transaction gets a read acknowledge
// - Snoops wait for earlier same-address read acknowledges
// - Same-identifier write responses in issue order
// - Write exclusive-OK only for noncoherent write
// - Write acknowledge one cycle, taken in that cycle
// - Write acknowledge after response, never postponed
// - Every write, barriers too, gets a write acknowledge
// - Snoops wait for earlier same-address write acknowledges
// - Acknowledges follow order of last beats and responses
module cra_master #(
   parameter int PEND_W = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cra_if.master lnk
);
   import cra_pkg::*;

   typedef enum logic [2:0] {
      CS_IDLE = 3'b001,
      CS_ADDR = 3'b010,
      CS_DONE = 3'b100
   } cra_chan_t;

   if (PEND_W < 1) begin : g_chk
      $error("PEND_W must be at least 1");
   end

   cra_chan_t rs_q, ws_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q, ctrl_q, wdata_q, rdata_q;
   logic [ADDR_W-1:0] addr_q;
   logic [3:0] rresp_q;
   logic [1:0] bresp_q;
   logic duty_q, shared_q, refused_q, nodata_q;
   logic ar_valid_q, r_ready_q, aw_valid_q, w_valid_q, b_ready_q;
   logic rd_ack_q, wr_ack_q;
   logic [PEND_W-1:0] rpend_q, wpend_q;
   cra_req_t ar_q, aw_q;
   logic acc, go, launch_rd, launch_wr, r_fin, b_fin, rfire, wfire;
   logic mapped;
   logic [31:0] status;
   cra_req_t req;

   // Write lands at the edge where pready is seen high
   assign acc = psel & penable & pready_q;
   assign go = acc & pwrite & (paddr == REG_CTRL) & pwdata[CTRL_GO_BIT];
   assign launch_rd = go & ~pwdata[CTRL_WRITE_BIT] & (rs_q == CS_IDLE);
   assign launch_wr = go & pwdata[CTRL_WRITE_BIT] & (ws_q == CS_IDLE);
   assign r_fin = lnk.r_valid & r_ready_q & lnk.r_last;
   assign b_fin = lnk.b_valid & b_ready_q;
   assign mapped = paddr inside {REG_CTRL, REG_ADDR, REG_WDATA, REG_STATUS,
      REG_RDATA};

   always_comb begin
      status = 32'h0000_0000;
      status[ST_RD_BUSY] = (rs_q != CS_IDLE);
      status[ST_WR_BUSY] = (ws_q != CS_IDLE);
      status[ST_RRESP_LSB +: 4] = rresp_q;
      status[ST_BRESP_LSB +: 2] = bresp_q;
      status[ST_DUTY] = duty_q;
      status[ST_SHARED] = shared_q;
      status[ST_REFUSED] = refused_q;
   end

   // Request attributes come from the command word being written
   always_comb begin
      req.request_address = addr_q;
      req.burst_beats = pwdata[CTRL_LEN_LSB +: 8];
      req.beat_size = SIZE_BUS;
      req.burst_kind = BURST_INCR;
      req.cache_attributes = pwdata[CTRL_CACHE_LSB +: 4];
      req.protection_field = pwdata[CTRL_PROT_LSB +: 3];
      req.lock_type = pwdata[CTRL_LOCK_BIT];
      req.snoop_type = pwdata[CTRL_KIND_LSB +: 4];
      req.barrier_flag = pwdata[CTRL_BAR_BIT];
      req.domain = pwdata[CTRL_DOMAIN_LSB +: 2];
      if (req.barrier_flag) begin
         req.request_address = '0;
         req.burst_beats = 8'h00;
         req.snoop_type = 4'h0;
         req.cache_attributes = CACHE_NORMAL_NC;
         req.lock_type = LOCK_NORMAL;
      end else if (!pwdata[CTRL_WRITE_BIT] && cra_single_beat(req)) begin
         req.burst_beats = 8'h00;
      end
      if (pwdata[CTRL_WRITE_BIT]) begin
         req.burst_beats = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~mapped;
         if (psel & penable & ~pready_q & ~pwrite) begin
            case (paddr)
               REG_CTRL: prdata_q <= ctrl_q;
               REG_ADDR: prdata_q <= addr_q;
               REG_WDATA: prdata_q <= wdata_q;
               REG_STATUS: prdata_q <= status;
               REG_RDATA: prdata_q <= rdata_q;
               default: prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTRL_RESET;
         addr_q <= '0;
         wdata_q <= 32'h0000_0000;
      end else if (acc & pwrite) begin
         if (paddr == REG_CTRL) ctrl_q <= pwdata;
         if (paddr == REG_ADDR) addr_q <= pwdata;
         if (paddr == REG_WDATA) wdata_q <= pwdata;
      end
   end

   // Sticky duty and refused flags: hardware set wins over software clear; shared follows each last beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_q <= 1'b0;
         shared_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         if (acc & pwrite & (paddr == REG_STATUS)) begin
            if (pwdata[ST_DUTY]) duty_q <= 1'b0;
            if (pwdata[ST_REFUSED]) refused_q <= 1'b0;
         end
         if (r_fin & lnk.r_resp[RESP_DUTY_BIT]) duty_q <= 1'b1;
         if (r_fin) shared_q <= lnk.r_resp[RESP_SHARED_BIT];
         if (go & ~launch_rd & ~launch_wr) refused_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_q <= CS_IDLE;
         ar_valid_q <= 1'b0;
         r_ready_q <= 1'b0;
         ar_q <= '0;
         nodata_q <= 1'b0;
      end else begin
         case (rs_q)
            CS_IDLE: if (launch_rd) begin
               ar_q <= req;
               nodata_q <= cra_single_beat(req);
               ar_valid_q <= 1'b1;
               rs_q <= CS_ADDR;
            end
            CS_ADDR: if (lnk.ar_ready) begin
               ar_valid_q <= 1'b0;
               r_ready_q <= 1'b1;
               rs_q <= CS_DONE;
            end
            CS_DONE: if (r_fin) begin
               r_ready_q <= 1'b0;
               rs_q <= CS_IDLE;
            end
            default: rs_q <= CS_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         rresp_q <= 4'h0;
      end else if (lnk.r_valid & r_ready_q) begin
         if (!nodata_q) rdata_q <= lnk.r_data;
         rresp_q <= lnk.r_resp;
      end
   end

   // Barrier writes carry no data beat
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ws_q <= CS_IDLE;
         aw_valid_q <= 1'b0;
         w_valid_q <= 1'b0;
         b_ready_q <= 1'b0;
         aw_q <= '0;
         bresp_q <= 2'h0;
      end else begin
         case (ws_q)
            CS_IDLE: if (launch_wr) begin
               aw_q <= req;
               aw_valid_q <= 1'b1;
               w_valid_q <= ~req.barrier_flag;
               ws_q <= CS_ADDR;
            end
            CS_ADDR: begin
               if (lnk.aw_ready) aw_valid_q <= 1'b0;
               if (lnk.w_ready) w_valid_q <= 1'b0;
               if ((~aw_valid_q | lnk.aw_ready) &
                   (~w_valid_q | lnk.w_ready)) begin
                  b_ready_q <= 1'b1;
                  ws_q <= CS_DONE;
               end
            end
            CS_DONE: if (b_fin) begin
               b_ready_q <= 1'b0;
               bresp_q <= lnk.b_resp;
               ws_q <= CS_IDLE;
            end
            default: ws_q <= CS_IDLE;
         endcase
      end
   end

   // Pulse in the cycle after completion; backlog drains one per cycle
   assign rfire = r_fin | (rpend_q != '0);
   assign wfire = b_fin | (wpend_q != '0);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ack_q <= 1'b0;
         wr_ack_q <= 1'b0;
         rpend_q <= '0;
         wpend_q <= '0;
      end else begin
         rd_ack_q <= rfire;
         wr_ack_q <= wfire;
         rpend_q <= rpend_q + PEND_W'(r_fin) - PEND_W'(rfire);
         wpend_q <= wpend_q + PEND_W'(b_fin) - PEND_W'(wfire);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign lnk.ar_valid = ar_valid_q;
   assign lnk.ar = ar_q;
   assign lnk.r_ready = r_ready_q;
   assign lnk.read_completion_ack = rd_ack_q;
   assign lnk.aw_valid = aw_valid_q;
   assign lnk.aw = aw_q;
   assign lnk.w_valid = w_valid_q;
   assign lnk.w_data = wdata_q;
   assign lnk.w_last = w_valid_q;
   assign lnk.b_ready = b_ready_q;
   assign lnk.write_completion_ack = wr_ack_q;
endmodule // cra_master

// ---- rtl/cra_fabric.sv ----
// Coherent interconnect end: responses, permitted bits, snoop gating
`timescale 1ns/10ps
module cra_fabric (
   input wire logic pclk,
   input wire logic presetn,
   cra_if.fabric lnk,
   input wire logic want_shared,
   input wire logic want_duty,
   input wire logic want_excl,
   input wire logic [cra_pkg::DATA_W-1:0] rsp_data,
   input wire logic [cra_pkg::ADDR_W-1:0] snoop_addr,
   output logic snoop_ok,
   output logic rd_ack_seen,
   output logic wr_ack_seen
);
   import cra_pkg::*;

   typedef enum logic [1:0] {
      FS_IDLE = 2'b01,
      FS_BUSY = 2'b10
   } cra_fst_t;

   cra_fst_t rs_q, ws_q;
   logic ar_ready_q, r_valid_q, r_last_q, aw_ready_q, w_ready_q, b_valid_q;
   logic [DATA_W-1:0] r_data_q;
   logic [3:0] r_resp_q;
   logic [1:0] b_resp_q;
   logic [7:0] left_q;
   logic nodata_q, aw_got_q, w_got_q;
   logic rd_open_q, wr_open_q, snoop_ok_q, rd_ack_seen_q, wr_ack_seen_q;
   logic [ADDR_W-1:0] rd_addr_q, wr_addr_q;
   cra_req_t aw_q;
   logic ar_hs, aw_hs, w_hs;

   // Coherency bits chosen once per burst, clipped to what the kind allows
   function automatic logic [3:0] rd_resp(input cra_req_t r);
      logic sh, dt, ex;
      sh = 1'b0;
      dt = 1'b0;
      ex = want_excl & r.lock_type & ~r.barrier_flag &
         (r.snoop_type inside {K_NONCOH_READ, K_CLEAN_COPY_READ,
         K_SHARED_READ, K_CLEAN_TO_OWN});
      if (!r.barrier_flag) begin
         case (r.snoop_type)
            K_SHARED_READ: begin
               sh = want_shared;
               dt = want_duty;
            end
            K_NONSHARED_DIRTY_READ: begin
               sh = want_shared;
               dt = want_duty & ~want_shared;
            end
            K_EXCL_COPY_READ: dt = want_duty;
            K_SNAPSHOT_READ, K_CLEAN_COPY_READ, K_CLEAN_KEEP:
               sh = want_shared;
            default: ;
         endcase
      end
      rd_resp = {sh, dt, ex ? RESP_EXCL_OK : RESP_OKAY};
   endfunction

   assign ar_hs = lnk.ar_valid & ar_ready_q;
   assign aw_hs = lnk.aw_valid & aw_ready_q;
   assign w_hs = lnk.w_valid & w_ready_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rs_q <= FS_IDLE;
         ar_ready_q <= 1'b0;
         r_valid_q <= 1'b0;
         r_last_q <= 1'b0;
         r_data_q <= '0;
         r_resp_q <= 4'h0;
         left_q <= 8'h00;
         nodata_q <= 1'b0;
      end else begin
         case (rs_q)
            FS_IDLE: begin
               ar_ready_q <= ~ar_hs;
               if (ar_hs) begin
                  left_q <= lnk.ar.burst_beats;
                  nodata_q <= cra_single_beat(lnk.ar);
                  r_resp_q <= rd_resp(lnk.ar);
                  r_data_q <= cra_single_beat(lnk.ar) ? '0 : rsp_data;
                  r_last_q <= (lnk.ar.burst_beats == 8'h00);
                  r_valid_q <= 1'b1;
                  rs_q <= FS_BUSY;
               end
            end
            FS_BUSY: if (lnk.r_ready) begin
               if (r_last_q) begin
                  r_valid_q <= 1'b0;
                  r_last_q <= 1'b0;
                  ar_ready_q <= 1'b1;
                  rs_q <= FS_IDLE;
               end else begin
                  left_q <= left_q - 8'h01;
                  r_last_q <= (left_q == 8'h01);
                  r_data_q <= nodata_q ? '0 : rsp_data;
               end
            end
            default: rs_q <= FS_IDLE;
         endcase
      end
   end

   // One write outstanding, so responses keep issue order
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ws_q <= FS_IDLE;
         aw_ready_q <= 1'b0;
         w_ready_q <= 1'b0;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_q <= '0;
         b_valid_q <= 1'b0;
         b_resp_q <= 2'h0;
      end else begin
         case (ws_q)
            FS_IDLE: begin
               aw_ready_q <= ~aw_got_q & ~aw_hs;
               w_ready_q <= ~w_got_q & ~w_hs;
               if (aw_hs) begin
                  aw_q <= lnk.aw;
                  aw_got_q <= 1'b1;
                  if (lnk.aw.barrier_flag) w_got_q <= 1'b1;
               end
               if (w_hs) w_got_q <= 1'b1;
               if (aw_got_q & w_got_q) begin
                  b_valid_q <= 1'b1;
                  b_resp_q <= (want_excl & aw_q.lock_type &
                     ~aw_q.barrier_flag &
                     (aw_q.snoop_type == K_NONCOH_WRITE)) ?
                     RESP_EXCL_OK : RESP_OKAY;
                  ws_q <= FS_BUSY;
               end
            end
            FS_BUSY: if (lnk.b_ready) begin
               b_valid_q <= 1'b0;
               aw_got_q <= 1'b0;
               w_got_q <= 1'b0;
               ws_q <= FS_IDLE;
            end
            default: ws_q <= FS_IDLE;
         endcase
      end
   end

   // Acks sampled every cycle; a new transaction's set beats the ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ack_seen_q <= 1'b0;
         wr_ack_seen_q <= 1'b0;
         rd_open_q <= 1'b0;
         wr_open_q <= 1'b0;
         rd_addr_q <= '0;
         wr_addr_q <= '0;
         snoop_ok_q <= 1'b0;
      end else begin
         rd_ack_seen_q <= lnk.read_completion_ack;
         wr_ack_seen_q <= lnk.write_completion_ack;
         if (lnk.read_completion_ack) rd_open_q <= 1'b0;
         if (ar_hs) begin
            rd_open_q <= 1'b1;
            rd_addr_q <= lnk.ar.request_address;
         end
         if (lnk.write_completion_ack) wr_open_q <= 1'b0;
         if (aw_hs) begin
            wr_open_q <= 1'b1;
            wr_addr_q <= lnk.aw.request_address;
         end
         snoop_ok_q <= ~((rd_open_q & (rd_addr_q[ADDR_W-1:LINE_OFS_W] ==
            snoop_addr[ADDR_W-1:LINE_OFS_W])) |
            (wr_open_q & (wr_addr_q[ADDR_W-1:LINE_OFS_W] ==
            snoop_addr[ADDR_W-1:LINE_OFS_W])));
      end
   end

   assign lnk.ar_ready = ar_ready_q;
   assign lnk.r_valid = r_valid_q;
   assign lnk.r_data = r_data_q;
   assign lnk.r_resp = r_resp_q;
   assign lnk.r_last = r_last_q;
   assign lnk.aw_ready = aw_ready_q;
   assign lnk.w_ready = w_ready_q;
   assign lnk.b_valid = b_valid_q;
   assign lnk.b_resp = b_resp_q;
   assign snoop_ok = snoop_ok_q;
   assign rd_ack_seen = rd_ack_seen_q;
   assign wr_ack_seen = wr_ack_seen_q;
endmodule // cra_fabric

// ---- tb/cra_link_monitor.sv ----
// Link checker: barrier request shape and completion acknowledges
`timescale 1ns/10ps
module cra_link_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ar_valid,
   input wire cra_pkg::cra_req_t ar,
   input wire logic aw_valid,
   input wire cra_pkg::cra_req_t aw,
   input wire logic r_valid,
   input wire logic r_ready,
   input wire logic r_last,
   input wire logic [3:0] r_resp,
   input wire logic b_valid,
   input wire logic b_ready,
   input wire logic read_completion_ack,
   input wire logic write_completion_ack
);
   import cra_pkg::*;
   logic rl, bh;
   assign rl = r_valid && r_ready && r_last;
   assign bh = b_valid && b_ready;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_rbar_shape:
   assert property (ar_valid && ar.barrier_flag |-> ar.request_address == '0
      && ar.burst_beats == 8'h00 && ar.burst_kind == BURST_INCR
      && ar.beat_size == SIZE_BUS && ar.snoop_type == 4'h0)
      else $error("barrier read shape");
   a_rbar_attr:
   assert property (ar_valid && ar.barrier_flag |->
      ar.cache_attributes == CACHE_NORMAL_NC && ar.lock_type == LOCK_NORMAL)
      else $error("barrier read attributes");
   a_wbar_shape:
   assert property (aw_valid && aw.barrier_flag |-> aw.request_address == '0
      && aw.burst_beats == 8'h00 && aw.snoop_type == 4'h0
      && aw.lock_type == LOCK_NORMAL
      && aw.cache_attributes == CACHE_NORMAL_NC)
      else $error("barrier write shape");
   a_one_beat:
   assert property (ar_valid && ar.snoop_type inside {[4'h6:4'hB]} |->
      ar.burst_beats == 8'h00) else $error("dataless read not one beat");
   a_rd_ack_prompt:
   assert property (rl |=> read_completion_ack) else $error("read ack late");
   a_rd_ack_cause:
   assert property (read_completion_ack |-> $past(rl))
      else $error("read ack without last beat");
   a_rd_ack_pulse:
   assert property (read_completion_ack |=> !read_completion_ack)
      else $error("read ack too long");
   a_wr_ack_prompt:
   assert property (bh |=> write_completion_ack) else $error("write ack late");
   a_wr_ack_cause:
   assert property (write_completion_ack |-> $past(bh))
      else $error("write ack without response");
   a_wr_ack_pulse:
   assert property (write_completion_ack |=> !write_completion_ack)
      else $error("write ack too long");
   a_resp_steady:
   assert property (r_valid && r_ready && !r_last ##1 r_valid |->
      $stable(r_resp)) else $error("coherency bits moved in burst");
   c_bar_read: cover property (ar_valid && ar.barrier_flag);
   c_wr_ack: cover property (write_completion_ack);
   c_both_bits: cover property (r_valid && r_resp[3:2] == 2'h3);
endmodule // cra_link_monitor

// ---- tb/tb_coherent_resp_ack.sv ----
// Self-checking bench: APB-driven master facing the fabric end
`timescale 1ns/10ps
module tb_coherent_resp_ack;
   import cra_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, rsp_data, snoop_addr, last_rd;
   logic want_shared, want_duty, want_excl, snoop_ok;
   logic rd_ack_seen, wr_ack_seen;
   logic [64:0] q[$];
   logic [64:0] ex;
   int n_fail, n_tests, n_rd_ack, n_wr_ack, e_rd_ack, e_wr_ack;
   cra_if u_cra_if (.pclk(pclk), .presetn(presetn));
   cra_master u_cra_master (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(u_cra_if));
   cra_fabric u_cra_fabric (.pclk(pclk), .presetn(presetn), .lnk(u_cra_if),
      .want_shared(want_shared), .want_duty(want_duty),
      .want_excl(want_excl), .rsp_data(rsp_data),
      .snoop_addr(snoop_addr), .snoop_ok(snoop_ok), .rd_ack_seen(rd_ack_seen),
      .wr_ack_seen(wr_ack_seen));
   cra_link_monitor u_cra_link_monitor (.pclk(pclk), .presetn(presetn),
      .ar_valid(u_cra_if.ar_valid), .ar(u_cra_if.ar),
      .aw_valid(u_cra_if.aw_valid), .aw(u_cra_if.aw),
      .r_valid(u_cra_if.r_valid), .r_ready(u_cra_if.r_ready),
      .r_last(u_cra_if.r_last), .r_resp(u_cra_if.r_resp),
      .b_valid(u_cra_if.b_valid), .b_ready(u_cra_if.b_ready),
      .read_completion_ack(u_cra_if.read_completion_ack),
      .write_completion_ack(u_cra_if.write_completion_ack));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [32:0] s, input logic [32:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // e packs {slave error, compare mask, expected data}
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [64:0] e);
      int i;
      q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (pready !== 1'b1) begin
         n_fail++;
         end_sim();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Results are judged where they appear, in request order
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         ex = q.pop_front();
         chk({pslverr, prdata & ex[63:32]},
            {ex[64], ex[31:0] & ex[63:32]});
      end
      n_rd_ack += int'(rd_ack_seen === 1'b1);
      n_wr_ack += int'(wr_ack_seen === 1'b1);
   end
   task automatic idle();
      int i;
      i = 0;
      do begin
         apb(1'b0, REG_STATUS, 32'h0, 65'h0);
         i++;
      end while (rd[1:0] !== 2'b00 && i < 50);
      if (rd[1:0] !== 2'b00) begin
         n_fail++;
         end_sim();
      end
   endtask
   function automatic logic [3:0] xresp(input logic [3:0] k, input logic l);
      logic s, d, e;
      s = want_shared && k inside {1, 2, 3, 4, 8};
      d = want_duty && k inside {3, 4, 5} && !(k == 3 && s);
      e = want_excl && l && k inside {0, 2, 4, 6};
      return {s, d, 1'b0, e};
   endfunction
   task automatic run(input int n);
      logic [3:0] k, x;
      logic w, b, l;
      logic [31:0] c;
      w = n > 12;
      b = n == 12 || n == 13;
      k = n < 12 ? n[3:0] : (n == 15 ? 4'h1 : 4'($urandom) & {4{b}});
      l = n >= 14 || 1'($urandom);
      want_shared <= 1'($urandom);
      want_duty <= 1'($urandom);
      want_excl <= n >= 14 || 1'($urandom);
      rsp_data <= $urandom;
      // Barrier gets junk attributes: the master must clean them up
      c = ($urandom & 32'h0F03_1F00) | {25'h0, l, b, w, k} | 32'h8000_0000;
      apb(1'b1, REG_ADDR, $urandom & 32'hFFFF_FFC0, 65'h0);
      apb(1'b1, REG_WDATA, $urandom, 65'h0);
      apb(1'b1, REG_CTRL, c, 65'h0);
      idle();
      x = b ? 4'h0 : xresp(k, l);
      if (w) begin
         e_wr_ack++;
         x[0] = want_excl && l && k == K_NONCOH_WRITE && !b;
         apb(1'b0, REG_STATUS, 0, {1'b0, 32'hC0, 24'h0, 1'b0, x[0], 6'h0});
      end else begin
         e_rd_ack++;
         apb(1'b0, REG_STATUS, 0,
            {1'b0, 32'h33C, 22'h0, x[3:2], 2'h0, x, 2'h0});
         if (!b && k < 6) last_rd = rsp_data;
         apb(1'b0, REG_RDATA, 0, {1'b0, 32'hFFFF_FFFF, last_rd});
         apb(1'b1, REG_STATUS, 32'h100, 65'h0);
      end
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {want_shared, want_duty, want_excl, rsp_data, snoop_addr} = '0;
      {n_fail, n_tests, n_rd_ack, n_wr_ack, e_rd_ack, e_wr_ack} = '0;
      last_rd = 32'h0;
      void'($urandom(32'hC1AD3EB1));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, REG_CTRL, 0, {1'b0, 32'hFFFF_FFFF, CTRL_RESET});
      apb(1'b0, REG_STATUS, 0, {1'b0, 32'hFFFF_FFFF, 32'h0});
      apb(1'b0, 8'h14, 0, {1'b1, 32'hFFFF_FFFF, 32'h0});
      for (int n = 0; n < 48; n++) run(n % 16);
      // Long burst keeps the line held while a second launch is refused
      apb(1'b1, REG_ADDR, 32'h0000_1040, 65'h0);
      apb(1'b1, REG_CTRL, 32'h800F_0000, 65'h0);
      snoop_addr <= 32'h0000_107C;
      apb(1'b1, REG_CTRL, 32'h8000_0000, 65'h0);
      chk({32'h0, snoop_ok}, 33'h0);
      apb(1'b0, REG_STATUS, 0, {1'b0, 32'h401, 32'h401});
      idle();
      e_rd_ack++;
      chk({32'h0, snoop_ok}, 33'h1);
      apb(1'b1, REG_STATUS, 32'h400, 65'h0);
      chk(33'(n_rd_ack), 33'(e_rd_ack));
      chk(33'(n_wr_ack), 33'(e_wr_ack));
      end_sim();
   end
endmodule // tb_coherent_resp_ack
